// *** include/iopg_pkg.sv ***
// Package of register offsets, widths and reset values for the input and I/O port group.
package iopg_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int unsigned REG_AW = 3;

    localparam logic [2:0] OFS_INPUT_PORT8_PIN_STATE  = 3'h0;
    localparam logic [2:0] OFS_INPUT_INPUT_PORT8_PIN_STATE_PIN_STATE  = 3'h1;
    localparam logic [2:0] OFS_BIDIR_PORT_DIRECTION   = 3'h2;
    localparam logic [2:0] OFS_BIDIR_PORT_OUTPUT_DATA = 3'h3;
    localparam logic [2:0] OFS_BIDIR_PORT_PIN_STATE   = 3'h4;

    // ************************************************************
    // Widths and reset values
    // ************************************************************
    localparam int unsigned IN8_W   = 8;
    localparam int unsigned IN4_W   = 4;
    localparam int unsigned BIDIR_W = 4;

    localparam logic [3:0] BIDIR_DIR_RESET = 4'h0;
    localparam logic [3:0] BIDIR_OUT_RESET = 4'h0;

    // Value returned for undefined bits and unreadable registers.
    localparam logic [7:0] UNDEF_READ = 8'h00;
    localparam logic [3:0] UNDEF_HIGH = 4'h0;

    // Reset value of the synchroniser flops.
    localparam logic SYNC_RESET = 1'b0;

endpackage : iopg_pkg

// *** rtl/iopg_sync.sv ***
// Two-flop synchroniser for a group of pin levels.
`timescale 1ns/1ps
`default_nettype none
module iopg_sync #(
    parameter int unsigned W = 8
) (
    input  wire logic         core_clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            meta_q   <= {W{iopg_pkg::SYNC_RESET}};
            sync_out <= {W{iopg_pkg::SYNC_RESET}};
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : iopg_sync
`default_nettype wire

// *** rtl/iopg_top.sv ***
// Input-only ports and one bidirectional port with their CPU register file.
//
// Function
// RULE1 - An eight-pin port exists that is input only, with no driver and no direction control.
// RULE2 - Reading the eight-pin port register returns the sampled levels of its pins, bit 7 to pin 7 down to bit 0.
// RULE3 - Writing the eight-pin port register changes neither its contents nor any pin.
// RULE4 - A four-pin input-only port reports its pins in bits 3 to 0 of an eight-bit read-only register.
// RULE5 - Reading the four-pin port register shows the pin levels in bits 3 to 0 and undefined bits 7 to 4.
// RULE6 - Writing the four-pin port register is ignored.
// RULE7 - A four-pin bidirectional port has a direction register, an output data register and a pin register.
// RULE8 - The direction register is eight bits, write only, and reads back an undefined value.
// RULE9 - A direction bit of 1 enables the pin's driver and 0 makes the pin an input.
// RULE10 - The output data register holds in bits 3 to 0 the driven level of each output pin and is read/write.
// RULE11 - Bits 7 to 4 of the output data register read back undefined.
// RULE12 - Reading the pin register returns the output data bit for each pin whose direction bit is 1.
// RULE13 - Reading the pin register returns the sampled pin level for each pin whose direction bit is 0.
// RULE14 - Writing the pin register is ignored and never alters output data or direction.
// RULE15 - Reset clears direction and output data bits 3 to 0 so every pin starts as an input.
// RULE16 - Pin levels are synchronised to the clock before reaching the read path.
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module iopg_top #(
    parameter int unsigned IN8_W   = iopg_pkg::IN8_W,
    parameter int unsigned IN4_W   = iopg_pkg::IN4_W,
    parameter int unsigned BIDIR_W = iopg_pkg::BIDIR_W
) (
    input  wire logic                        core_clk,
    input  wire logic                        nrst,
    input  wire logic [iopg_pkg::REG_AW-1:0] reg_addr,
    input  wire logic [7:0]                  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output var  logic [7:0]                  reg_rdata,
    input  wire logic [IN8_W-1:0]            input8_pin_in,
    input  wire logic [IN4_W-1:0]            input4_pin_in,
    input  wire logic [BIDIR_W-1:0]          bidir_pin_in,
    output var  logic [BIDIR_W-1:0]          bidir_pin_out,
    output var  logic [BIDIR_W-1:0]          bidir_pin_oe
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [IN8_W-1:0]   in8_sync;
    logic [IN4_W-1:0]   in4_sync;
    logic [BIDIR_W-1:0] bidir_sync;

    iopg_sync #(.W(IN8_W)) u_sync_in8 ( // RULE16
        .core_clk (core_clk),
        .nrst     (nrst),
        .async_in (input8_pin_in),
        .sync_out (in8_sync)
    );

    iopg_sync #(.W(IN4_W)) u_sync_in4 ( // RULE16
        .core_clk (core_clk),
        .nrst     (nrst),
        .async_in (input4_pin_in),
        .sync_out (in4_sync)
    );

    iopg_sync #(.W(BIDIR_W)) u_sync_bidir ( // RULE16
        .core_clk (core_clk),
        .nrst     (nrst),
        .async_in (bidir_pin_in),
        .sync_out (bidir_sync)
    );

    // ************************************************************
    // Bidirectional port control registers
    // ************************************************************
    logic [BIDIR_W-1:0] bidir_dir_q;
    logic [BIDIR_W-1:0] bidir_out_q;

    logic wr_dir;
    logic wr_out;
    assign wr_dir = reg_wr && (reg_addr == iopg_pkg::OFS_BIDIR_PORT_DIRECTION);
    assign wr_out = reg_wr && (reg_addr == iopg_pkg::OFS_BIDIR_PORT_OUTPUT_DATA);

    // Only the low bits are kept; the upper bits of the direction byte have no storage.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            bidir_dir_q <= BIDIR_W'(iopg_pkg::BIDIR_DIR_RESET); // RULE15
        end else if (wr_dir) begin
            bidir_dir_q <= reg_wdata[BIDIR_W-1:0]; // RULE8
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            bidir_out_q <= BIDIR_W'(iopg_pkg::BIDIR_OUT_RESET); // RULE15
        end else if (wr_out) begin
            bidir_out_q <= reg_wdata[BIDIR_W-1:0]; // RULE10
        end
    end

    // Writes to the pin state registers decode to nothing and are dropped.
    // RULE3
    // RULE6
    // RULE14

    // ************************************************************
    // Pin drivers
    // ************************************************************
    // The input-only ports have no driver outputs at all.
    // RULE1
    // RULE7
    assign bidir_pin_oe  = bidir_dir_q; // RULE9
    assign bidir_pin_out = bidir_out_q; // RULE10

    // ************************************************************
    // Read path
    // ************************************************************
    logic [BIDIR_W-1:0] bidir_state;
    logic [7:0]         rd_mux;

    // Outputs read back from the latch, so a loaded pin cannot disturb software's view.
    genvar gi;
    generate
        for (gi = 0; gi < BIDIR_W; gi++) begin : g_state
            assign bidir_state[gi] = bidir_dir_q[gi] ? bidir_out_q[gi] // RULE12
                                                     : bidir_sync[gi]; // RULE13
        end
    endgenerate

    always_comb begin
        rd_mux = iopg_pkg::UNDEF_READ;
        unique case (reg_addr)
            iopg_pkg::OFS_INPUT_PORT8_PIN_STATE: begin
                rd_mux = 8'(in8_sync); // RULE2
            end
            iopg_pkg::OFS_INPUT_INPUT_PORT8_PIN_STATE_PIN_STATE: begin
                rd_mux = {iopg_pkg::UNDEF_HIGH, 4'(in4_sync)}; // RULE4 RULE5
            end
            iopg_pkg::OFS_BIDIR_PORT_DIRECTION: begin
                rd_mux = iopg_pkg::UNDEF_READ; // RULE8
            end
            iopg_pkg::OFS_BIDIR_PORT_OUTPUT_DATA: begin
                rd_mux = {iopg_pkg::UNDEF_HIGH, 4'(bidir_out_q)}; // RULE11
            end
            iopg_pkg::OFS_BIDIR_PORT_PIN_STATE: begin
                rd_mux = {iopg_pkg::UNDEF_HIGH, 4'(bidir_state)};
            end
            default: begin
                rd_mux = iopg_pkg::UNDEF_READ;
            end
        endcase
    end

    // Read data is held until the next read strobe.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            reg_rdata <= iopg_pkg::UNDEF_READ;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end
    end

endmodule : iopg_top
`default_nettype wire

// *** test/iopg_board.sv ***
// Board model that resolves the bidirectional pins.
`timescale 1ns/1ps
`default_nettype none
module iopg_board (
    input  wire logic [3:0] bidir_pin_out,
    input  wire logic [3:0] bidir_pin_oe,
    input  wire logic [3:0] board_level,
    output var  logic [3:0] bidir_pin_in
);
    // A driven pin shows the device level, an undriven one the board level.
    always_comb bidir_pin_in = (bidir_pin_oe & bidir_pin_out) | (~bidir_pin_oe & board_level);
endmodule : iopg_board
`default_nettype wire

// *** test/iopg_checker.sv ***
// Assertions on the register port and pin outputs of the port group.
`timescale 1ns/1ps
`default_nettype none
module iopg_checker (
    input wire logic       core_clk,
    input wire logic       nrst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] input8_pin_in,
    input wire logic [3:0] input4_pin_in,
    input wire logic [3:0] bidir_pin_in,
    input wire logic [3:0] bidir_pin_out,
    input wire logic [3:0] bidir_pin_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    AST_DIR_WR: assert property (reg_wr && reg_addr == 3'h2 |=> bidir_pin_oe == $past(reg_wdata[3:0]))
        else $error("direction write lost");
    AST_OUT_WR: assert property (reg_wr && reg_addr == 3'h3 |=> bidir_pin_out == $past(reg_wdata[3:0]))
        else $error("output write lost");
    AST_HOLD: assert property (!(reg_wr && reg_addr inside {3'h2, 3'h3}) |=> $stable({bidir_pin_oe, bidir_pin_out}))
        else $error("pin control changed");
    AST_RST: assert property ($rose(nrst) |-> bidir_pin_oe == 4'h0 && bidir_pin_out == 4'h0)
        else $error("pin control not cleared");
    AST_DIR_RD: assert property (reg_rd && reg_addr == 3'h2 |=> reg_rdata == iopg_pkg::UNDEF_READ)
        else $error("direction readable");
    // Pins must be settled over both synchroniser stages before the read.
    AST_IN8: assert property (reg_rd && reg_addr == 3'h0 && $past(nrst) && $past(nrst, 2) && $stable(input8_pin_in)
        && $past(input8_pin_in, 2) == input8_pin_in |=> reg_rdata == $past(input8_pin_in)) else $error("port8 read");
    AST_IN4: assert property (reg_rd && reg_addr == 3'h1 && $past(nrst) && $past(nrst, 2) && $stable(input4_pin_in)
        && $past(input4_pin_in, 2) == input4_pin_in |=> reg_rdata[3:0] == $past(input4_pin_in)) else $error("input_port8_pin_state read");
    AST_PIN: assert property (reg_rd && reg_addr == 3'h4 && $past(nrst) && $past(nrst, 2) && $stable(bidir_pin_in)
        && $past(bidir_pin_in, 2) == bidir_pin_in |=> reg_rdata[3:0] == ($past(bidir_pin_oe) & $past(bidir_pin_out)
        | ~$past(bidir_pin_oe) & $past(bidir_pin_in))) else $error("pin state read");
endmodule : iopg_checker
bind iopg_top iopg_checker u_iopg_checker (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .input8_pin_in, .input4_pin_in, .bidir_pin_in, .bidir_pin_out, .bidir_pin_oe);
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking testbench for the port group.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic       core_clk = 1'b0;
    logic       nrst     = 1'b0;
    logic [2:0] adr      = 3'h0;
    logic [7:0] wd       = 8'h00;
    logic       wr_q     = 1'b0;
    logic       rd_q     = 1'b0;
    logic [7:0] rdat;
    logic [7:0] in8      = 8'h00;
    logic [3:0] in4      = 4'h0;
    logic [3:0] lvl      = 4'h0;
    logic [3:0] pin;
    logic [3:0] po;
    logic [3:0] oe;
    int         fails    = 0;
    int         num_checks = 0;
    always #50 core_clk = ~core_clk;
    iopg_top u_iopg_top (.core_clk, .nrst, .reg_addr(adr), .reg_wdata(wd), .reg_wr(wr_q), .reg_rd(rd_q),
        .reg_rdata(rdat), .input8_pin_in(in8), .input4_pin_in(in4), .bidir_pin_in(pin), .bidir_pin_out(po),
        .bidir_pin_oe(oe));
    iopg_board u_iopg_board (.bidir_pin_out(po), .bidir_pin_oe(oe), .board_level(lvl), .bidir_pin_in(pin));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        wr_q <= 1'b1;
        adr  <= a;
        wd   <= d;
        @(posedge core_clk);
        wr_q <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
        @(posedge core_clk);
        rd_q <= 1'b1;
        adr  <= a;
        @(posedge core_clk);
        rd_q <= 1'b0;
        #1;
        chk(what, exp, rdat);
    endtask : rd
    task automatic t_inputs;
        logic [7:0] pats [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
        foreach (pats[i]) begin
            @(posedge core_clk);
            in8 <= pats[i];
            in4 <= pats[i][3:0];
            wr(3'h0, ~pats[i]);
            wr(3'h1, ~pats[i]);
            rd(3'h0, pats[i], "port8");
            rd(3'h1, {iopg_pkg::UNDEF_HIGH, pats[i][3:0]}, "input_port8_pin_state");
        end
        $display("inputs test done");
    endtask : t_inputs
    task automatic t_bidir;
        chk("enable", 8'h00, {4'h0, oe});
        rd(3'h3, 8'h00, "out data");
        @(posedge core_clk);
        lvl <= 4'hA;
        wr(3'h2, 8'hF5);
        chk("enable", 8'h05, {4'h0, oe});
        wr(3'h3, 8'hA3);
        chk("level", 8'h03, {4'h0, po});
        rd(3'h3, {iopg_pkg::UNDEF_HIGH, 4'h3}, "out data");
        rd(3'h2, iopg_pkg::UNDEF_READ, "direction");
        rd(3'h4, {iopg_pkg::UNDEF_HIGH, 4'hB}, "pin state");
        wr(3'h4, 8'hFF);
        wr(3'h5, 8'hFF);
        chk("enable", 8'h05, {4'h0, oe});
        chk("level", 8'h03, {4'h0, po});
        // A read right after the write must come from the latch, since the synchronised pins still lag.
        wr(3'h3, 8'h0C);
        rd(3'h4, {iopg_pkg::UNDEF_HIGH, 4'hE}, "latched state");
        rd(3'h6, iopg_pkg::UNDEF_READ, "unmapped");
        $display("bidir test done");
    endtask : t_bidir
    task automatic t_reset;
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        #1;
        chk("enable", 8'h00, {4'h0, oe});
        chk("level", 8'h00, {4'h0, po});
        rd(3'h3, {iopg_pkg::UNDEF_HIGH, 4'h0}, "out data");
        $display("reset test done");
    endtask : t_reset
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    initial begin
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        #1;
        t_bidir();
        t_reset();
        t_inputs();
        final_report();
    end
    // The tests need under 200 cycles, so 1000 cycles means a hang.
    initial begin
        #100000;
        fails++;
        final_report();
    end
endmodule : testbench
`default_nettype wire
